// ---- bench/iosled_chk.sv ----
// Concurrent checks on the ports of the sampling and indicator block
`timescale 1ns/100ps
`default_nettype none
module iosled_chk (
    input wire logic        CLK,
    input wire logic        SRST,
    input wire logic [12:0] DIO_OE,
    input wire logic [12:0] PULLUP_EN,
    input wire logic [2:0]  ADC_SEL,
    input wire logic        RX_SAMPLE_VALID,
    input wire logic [7:0]  RX_SAMPLE_DATA,
    input wire logic        FWD_VALID,
    input wire logic [7:0]  FWD_DATA,
    input wire logic        NODE_ID_TX,
    input wire logic        SMP_VALID,
    input wire logic [7:0]  SMP_DATA,
    input wire logic        SMP_LAST,
    input wire logic        SMP_READY
);
    logic first_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    // ====
    // Helper: next byte opens a set
    always_ff @(posedge CLK) begin
        if (SRST) first_q <= 1'b1;
        else if (SMP_VALID && SMP_READY) first_q <= SMP_LAST;
    end
    // ====
    // Assertions
    a_fwd_cause: assert property (FWD_VALID |-> $past(RX_SAMPLE_VALID))
        else $error("forward without received byte");
    a_fwd_data: assert property (FWD_VALID |-> FWD_DATA == $past(RX_SAMPLE_DATA))
        else $error("forward data differs");
    a_pullup_input: assert property ((PULLUP_EN & DIO_OE) == 13'h0)
        else $error("pull-up on a driven line");
    a_nodeid_pulse: assert property (NODE_ID_TX |=> !NODE_ID_TX)
        else $error("node id pulse too long");
    a_count_first: assert property (SMP_VALID && first_q |-> SMP_DATA == 8'h01)
        else $error("set does not open with count 1");
    a_byte_held: assert property (SMP_VALID && !SMP_READY |=> SMP_VALID && $stable(SMP_DATA))
        else $error("stalled byte not held");
    a_last_valid: assert property (SMP_LAST |-> SMP_VALID)
        else $error("last flag without byte");
    a_adc_range: assert property (ADC_SEL <= 3'h5)
        else $error("analog channel beyond five");
endmodule : iosled_chk
bind iosled_top iosled_chk iosled_chk_inst (.CLK, .SRST, .DIO_OE, .PULLUP_EN, .ADC_SEL,
    .RX_SAMPLE_VALID, .RX_SAMPLE_DATA, .FWD_VALID, .FWD_DATA, .NODE_ID_TX, .SMP_VALID,
    .SMP_DATA, .SMP_LAST, .SMP_READY);
`default_nettype wire

// ---- bench/iosled_host.sv ----
// Host side model: sample stream sink and analog source
`timescale 1ns/100ps
`default_nettype none
module iosled_host (
    input wire logic        CLK,
    input wire logic        SMP_VALID,
    input wire logic [7:0]  SMP_DATA,
    input wire logic [2:0]  ADC_SEL,
    output logic            SMP_READY,
    output logic     [15:0] ADC_DATA
);
    logic [7:0] bytes_q [$];
    logic [1:0] cnt_q = 2'h0;
    // Stalls one cycle in four so held bytes are exercised
    assign SMP_READY = cnt_q != 2'h3;
    assign ADC_DATA = {13'h0020, ADC_SEL};
    always @(posedge CLK) begin
        cnt_q <= cnt_q + 2'h1;
        if (SMP_VALID && SMP_READY) bytes_q.push_back(SMP_DATA);
    end
endmodule : iosled_host
`default_nettype wire

// ---- bench/iosled_top_test.sv ----
// Testbench for the sampling and indicator block
`timescale 1ns/100ps
`default_nettype none
module iosled_top_test;
    import iosled_pkg::*;
    logic CLK = 1'b0, SRST = 1'b1, WR = 1'b0, RD = 1'b0, RX_SAMPLE_VALID = 1'b0;
    logic RX_NODE_ID = 1'b0, SLEEPING = 1'b0, SYNCED = 1'b1, NET_ASLEEP = 1'b0, WAKE_START = 1'b0;
    logic [7:0] ADDR = 8'h00, RX_SAMPLE_DATA = 8'h00, FWD_DATA, SMP_DATA;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic [12:0] DIO_IN = 13'h0002, DIO_OUT, DIO_OE, PULLUP_EN;
    logic [2:0] ADC_SEL;
    logic [15:0] ADC_DATA;
    logic [63:0] SMP_DEST;
    logic STAY_AWAKE, NODE_ID_TX, FWD_VALID, SMP_VALID, SMP_LAST, SMP_TO_SERIAL, SMP_API_FRAME;
    logic SMP_READY;
    int n_errors = 0, num_checks = 0, n;
    iosled_top #(.TICK_CYC(10)) iosled_top_inst (.CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA,
        .DIO_IN, .DIO_OUT, .DIO_OE, .PULLUP_EN, .ADC_SEL, .ADC_DATA, .SLEEPING, .SYNCED,
        .NET_ASLEEP, .WAKE_START, .STAY_AWAKE, .RX_NODE_ID, .NODE_ID_TX, .RX_SAMPLE_VALID,
        .RX_SAMPLE_DATA, .FWD_VALID, .FWD_DATA, .SMP_VALID, .SMP_DATA, .SMP_LAST,
        .SMP_TO_SERIAL, .SMP_API_FRAME, .SMP_DEST, .SMP_READY);
    iosled_host host_inst (.CLK, .SMP_VALID, .SMP_DATA, .ADC_SEL, .SMP_READY, .ADC_DATA);
    initial forever #50 CLK = ~CLK;
    // ====
    // Shared tasks
    task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk(RDATA, e);
    endtask : rdc
    // Cycles until the indicator flips, capped
    task automatic tog(output int c);
        logic v;
        v = DIO_OUT[5];
        c = 0;
        while (DIO_OUT[5] === v && c < 12000) begin
            @(posedge CLK);
            #1 c++;
        end
    endtask : tog
    task automatic t_blink(input logic [31:0] ctrl, input logic [31:0] lt, input int e);
        wr(REG_CTRL, ctrl);
        wr(REG_BLINK, lt);
        tog(n);
        tog(n);
        chk(n, e);
    endtask : t_blink
    task automatic until_tx(input int lim);
        #1 n = 0;
        while (NODE_ID_TX !== 1'b1 && n < lim) begin
            @(posedge CLK);
            #1 n++;
        end
    endtask : until_tx
    task automatic get_set(input logic [7:0] e []);
        int i = 0;
        while (host_inst.bytes_q.size() < e.size() && i < 300) begin
            @(posedge CLK);
            i++;
        end
        chk(host_inst.bytes_q.size(), e.size());
        foreach (e[k]) chk(host_inst.bytes_q[k], e[k]);
    endtask : get_set
    task automatic final_report;
        if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // ====
    // Scenarios
    initial begin
        repeat (3) @(posedge CLK);
        SRST <= 1'b0;
        rdc(REG_PINCFG_LO, 32'h0010_0001);
        rdc(8'h30, 32'h0);
        chk(DIO_OE[5], 1'b1);
        t_blink(32'h0, 32'h0, 2500);
        t_blink(32'h0, 32'h5, 500);
        t_blink(32'h17, 32'h0, 5000);
        t_blink(32'h8, 32'h0, 2500);
        SYNCED <= 1'b0;
        repeat (3000) @(posedge CLK);
        chk(DIO_OUT[5], 1'b1);
        SLEEPING <= 1'b1;
        repeat (20) @(posedge CLK);
        chk(DIO_OUT[5], 1'b0);
        SLEEPING <= 1'b0;
        wr(REG_CTRL, 32'h20);
        @(posedge CLK);
        RX_NODE_ID <= 1'b1;
        @(posedge CLK);
        RX_NODE_ID <= 1'b0;
        tog(n);
        tog(n);
        tog(n);
        chk(n, 500);
        wr(REG_COMMAND, 32'h2);
        until_tx(10);
        chk(n, 0);
        wr(REG_CTRL, 32'h21);
        wr(REG_COMMAND, 32'h2);
        until_tx(20);
        chk(n, 20);
        wr(REG_WAKE_HOLD, 32'h2);
        WAKE_START <= 1'b1;
        @(posedge CLK);
        WAKE_START <= 1'b0;
        until_tx(4);
        chk({n < 4, STAY_AWAKE}, 2'b11);
        wr(REG_PINCFG_LO, 32'h0010_0232);
        wr(REG_PULLUP, 32'h1fff);
        #1 chk(PULLUP_EN, 13'h1fda);
        host_inst.bytes_q.delete();
        wr(REG_COMMAND, 32'h1);
        get_set('{8'h01, 8'h00, 8'h02, 8'h05, 8'h00, 8'h02, 8'h01, 8'h00, 8'h01, 8'h02});
        chk({SMP_TO_SERIAL, SMP_API_FRAME}, 2'b11);
        wr(REG_DEST_HI, 32'h1234_5678);
        wr(REG_DEST_LO, 32'h9abc_def0);
        wr(REG_CHANGE, 32'h2);
        host_inst.bytes_q.delete();
        DIO_IN <= 13'h0;
        get_set('{8'h01, 8'h00, 8'h02, 8'h05, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02});
        chk({SMP_TO_SERIAL, SMP_DEST}, {1'b0, 64'h1234_5678_9abc_def0});
        chk(STAY_AWAKE, 1'b0);
        wr(REG_CHANGE, 32'h0);
        wr(REG_PERIOD, 32'h3);
        host_inst.bytes_q.delete();
        get_set('{8'h01, 8'h00, 8'h02, 8'h05, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02});
        wr(REG_PERIOD, 32'h0);
        repeat (40) @(posedge CLK);
        host_inst.bytes_q.delete();
        repeat (100) @(posedge CLK);
        chk(host_inst.bytes_q.size(), 0);
        for (int api = 1; api >= 0; api--) begin
            wr(REG_CTRL, {26'h0, api[0], 5'h0});
            @(posedge CLK);
            RX_SAMPLE_VALID <= 1'b1;
            RX_SAMPLE_DATA <= 8'h5a;
            @(posedge CLK);
            RX_SAMPLE_VALID <= 1'b0;
            #1 chk({FWD_VALID, FWD_DATA & {8{api[0]}}}, {api[0], 8'h5a & {8{api[0]}}});
        end
        host_inst.bytes_q.delete();
        wr(REG_COMMAND, 32'h1);
        get_set('{8'h01, 8'h0d, 8'h00, 8'h02, 8'h0d, 8'h05, 8'h0d, 8'h00, 8'h00, 8'h0d,
            8'h01, 8'h00, 8'h0d, 8'h01, 8'h02, 8'h0d});
        final_report();
    end
    // Cut a hang short past the run length
    initial begin
        repeat (90000) @(posedge CLK);
        n_errors++;
        final_report();
    end
endmodule : iosled_top_test
`default_nettype wire

// ---- design/iosled_pkg.sv ----
// Package with constants for the I/O sampling and status indicator block
package iosled_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_FREQ_HZ       = 10000000;
    localparam int TICK_TIME_MS      = 1;
    localparam int TICK_CYCLES       = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
    localparam int BLINK_COORD_MS    = 500;
    localparam int BLINK_NORMAL_MS   = 250;
    localparam int ID_FLASH_MS       = 1000;
    localparam int ID_BLINK_MS       = 50;
    localparam int OVERRIDE_UNIT_MS  = 10;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_BLINK     = 8'h04;
    localparam logic [7:0] REG_PERIOD    = 8'h08;
    localparam logic [7:0] REG_CHANGE    = 8'h0c;
    localparam logic [7:0] REG_PULLUP    = 8'h10;
    localparam logic [7:0] REG_PINCFG_LO = 8'h14;
    localparam logic [7:0] REG_PINCFG_HI = 8'h18;
    localparam logic [7:0] REG_DEST_HI   = 8'h1c;
    localparam logic [7:0] REG_DEST_LO   = 8'h20;
    localparam logic [7:0] REG_WAKE_HOLD = 8'h24;
    localparam logic [7:0] REG_COMMAND   = 8'h28;
    localparam logic [7:0] REG_STATUS    = 8'h2c;

    // ==========================================================
    // Fields and reset values
    localparam int NUM_DIO = 13;
    localparam int NUM_ANA = 6;
    localparam int ASSOCIATION_INDICATOR_PIN_PIN = 5;
    localparam int BUTTON_PIN = 0;
    localparam logic [31:0] PINCFG_LO_RST = 32'h0010_0001;
    localparam logic [31:0] PINCFG_HI_RST = 32'h0000_0000;
    localparam logic [3:0] PIN_UNMON  = 4'h0;
    localparam logic [3:0] PIN_ALT1   = 4'h1;
    localparam logic [3:0] PIN_ANALOG = 4'h2;
    localparam logic [3:0] PIN_MON    = 4'h3;
    localparam logic [3:0] PIN_OUT_LO = 4'h4;
    localparam logic [3:0] PIN_OUT_HI = 4'h5;
    localparam logic [7:0] SAMPLE_SETS = 8'h01;
    localparam logic [7:0] CR_BYTE     = 8'h0d;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000, ST_CNT = 4'b0001, ST_DMH = 4'b0011, ST_DML = 4'b0010,
        ST_AM   = 4'b0110, ST_DSH = 4'b0111, ST_DSL = 4'b0101, ST_AH  = 4'b0100,
        ST_AL   = 4'b1100, ST_CR  = 4'b1101
    } iosled_state_t;
endpackage : iosled_pkg

// ---- design/iosled_top.sv ----
// Status indicator and I/O line sampling logic
`timescale 1ns/100ps
`default_nettype none
module iosled_top
    import iosled_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input  wire logic                 CLK,
    input  wire logic                 SRST,
    input  wire logic [7:0]           ADDR,
    input  wire logic [31:0]          WDATA,
    input  wire logic                 WR,
    input  wire logic                 RD,
    output logic      [31:0]          RDATA,
    input  wire logic [NUM_DIO-1:0]   DIO_IN,
    output logic      [NUM_DIO-1:0]   DIO_OUT,
    output logic      [NUM_DIO-1:0]   DIO_OE,
    output logic      [NUM_DIO-1:0]   PULLUP_EN,
    output logic      [2:0]           ADC_SEL,
    input  wire logic [15:0]          ADC_DATA,
    input  wire logic                 SLEEPING,
    input  wire logic                 SYNCED,
    input  wire logic                 NET_ASLEEP,
    input  wire logic                 WAKE_START,
    output logic                      STAY_AWAKE,
    input  wire logic                 RX_NODE_ID,
    output logic                      NODE_ID_TX,
    input  wire logic                 RX_SAMPLE_VALID,
    input  wire logic [7:0]           RX_SAMPLE_DATA,
    output logic                      FWD_VALID,
    output logic      [7:0]           FWD_DATA,
    output logic                      SMP_VALID,
    output logic      [7:0]           SMP_DATA,
    output logic                      SMP_LAST,
    output logic                      SMP_TO_SERIAL,
    output logic                      SMP_API_FRAME,
    output logic      [63:0]          SMP_DEST,
    input  wire logic                 SMP_READY
);
    // ==========================================================
    // Register file
    logic [3:0]           sleep_mode_q;
    logic                 coord_q;
    logic                 api_mode_q;
    logic [7:0]           blink_time_override_q;
    logic [15:0]          sample_period_ms_q;
    logic [NUM_DIO-1:0]   change_detect_mask_q;
    logic [NUM_DIO-1:0]   pullup_enable_mask_q;
    logic [31:0]          pincfg_lo_q;
    logic [31:0]          pincfg_hi_q;
    logic [31:0]          destination_addr_high_q;
    logic [31:0]          destination_addr_low_q;
    logic [15:0]          wake_hold_time_q;
    logic                 query_cmd;
    logic                 button_cmd;
    logic [63:0]          pincfg_all;
    logic [3:0]           indicator_pin_config;
    logic                 association_indicator_pin_q;
    logic                 busy;
    logic [NUM_DIO-1:0]   dio_s_q;

    assign pincfg_all           = {pincfg_hi_q, pincfg_lo_q};
    assign indicator_pin_config = pincfg_lo_q[4*ASSOCIATION_INDICATOR_PIN_PIN +: 4];
    assign query_cmd            = WR && ADDR == REG_COMMAND && WDATA[0];
    assign button_cmd           = WR && ADDR == REG_COMMAND && WDATA[1];

    always_ff @(posedge CLK) begin
        if (SRST) begin
            sleep_mode_q            <= 4'h0;
            coord_q                 <= 1'b0;
            api_mode_q              <= 1'b0;
            blink_time_override_q   <= 8'h00;
            sample_period_ms_q      <= 16'h0000;
            change_detect_mask_q    <= '0;
            pullup_enable_mask_q    <= '0;
            pincfg_lo_q             <= PINCFG_LO_RST;
            pincfg_hi_q             <= PINCFG_HI_RST;
            destination_addr_high_q <= 32'h0000_0000;
            destination_addr_low_q  <= 32'h0000_0000;
            wake_hold_time_q        <= 16'h0000;
        end else if (WR) begin
            case (ADDR)
                REG_CTRL: begin
                    sleep_mode_q <= WDATA[3:0];
                    coord_q      <= WDATA[4];
                    api_mode_q   <= WDATA[5];
                end
                REG_BLINK:     blink_time_override_q   <= WDATA[7:0];
                REG_PERIOD:    sample_period_ms_q      <= WDATA[15:0];
                REG_CHANGE:    change_detect_mask_q    <= WDATA[NUM_DIO-1:0];
                REG_PULLUP:    pullup_enable_mask_q    <= WDATA[NUM_DIO-1:0];
                REG_PINCFG_LO: pincfg_lo_q             <= WDATA;
                REG_PINCFG_HI: pincfg_hi_q             <= {12'h000, WDATA[19:0]};
                REG_DEST_HI:   destination_addr_high_q <= WDATA;
                REG_DEST_LO:   destination_addr_low_q  <= WDATA;
                REG_WAKE_HOLD: wake_hold_time_q        <= WDATA[15:0];
                default: ;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (SRST || !RD) begin
            RDATA <= 32'h0000_0000;
        end else begin
            case (ADDR)
                REG_CTRL:      RDATA <= {26'h0, api_mode_q, coord_q, sleep_mode_q};
                REG_BLINK:     RDATA <= {24'h0, blink_time_override_q};
                REG_PERIOD:    RDATA <= {16'h0, sample_period_ms_q};
                REG_CHANGE:    RDATA <= {19'h0, change_detect_mask_q};
                REG_PULLUP:    RDATA <= {19'h0, pullup_enable_mask_q};
                REG_PINCFG_LO: RDATA <= pincfg_lo_q;
                REG_PINCFG_HI: RDATA <= pincfg_hi_q;
                REG_DEST_HI:   RDATA <= destination_addr_high_q;
                REG_DEST_LO:   RDATA <= destination_addr_low_q;
                REG_WAKE_HOLD: RDATA <= {16'h0, wake_hold_time_q};
                REG_STATUS:    RDATA <= {16'h0, dio_s_q, STAY_AWAKE, busy, association_indicator_pin_q};
                default:       RDATA <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Pin synchronisers and per-pin function
    logic [NUM_DIO-1:0] dio_m_q;
    logic [NUM_DIO-1:0] dio_prev_q;
    logic [NUM_DIO-1:0] dmask;
    logic [NUM_ANA-1:0] amask;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            dio_m_q    <= '0;
            dio_s_q    <= '0;
            dio_prev_q <= '0;
        end else begin
            dio_m_q    <= DIO_IN;
            dio_s_q    <= dio_m_q;
            dio_prev_q <= dio_s_q;
        end
    end

    for (genvar i = 0; i < NUM_DIO; i++) begin : g_pin
        logic [3:0] cfg;
        assign cfg = pincfg_all[4*i +: 4];
        assign dmask[i] = cfg == PIN_MON || cfg == PIN_OUT_LO || cfg == PIN_OUT_HI;
        assign PULLUP_EN[i] = pullup_enable_mask_q[i]
                              && (cfg == PIN_UNMON || cfg == PIN_MON);
        if (i < NUM_ANA) begin : g_ana
            assign amask[i] = cfg == PIN_ANALOG;
        end
        always_ff @(posedge CLK) begin
            if (SRST) begin
                DIO_OUT[i] <= 1'b0;
                DIO_OE[i]  <= 1'b0;
            end else if (i == ASSOCIATION_INDICATOR_PIN_PIN && cfg == PIN_ALT1) begin
                DIO_OUT[i] <= association_indicator_pin_q;
                DIO_OE[i]  <= 1'b1;
            end else begin
                DIO_OUT[i] <= cfg == PIN_OUT_HI;
                DIO_OE[i]  <= cfg == PIN_OUT_LO || cfg == PIN_OUT_HI;
            end
        end
    end

    // ==========================================================
    // Millisecond tick
    logic [15:0] tick_cnt_q;
    logic        ms_tick;

    assign ms_tick = tick_cnt_q == 16'(TICK_CYC - 1);
    always_ff @(posedge CLK) begin
        if (SRST || ms_tick) begin
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end

    // ==========================================================
    // Status indicator
    logic [15:0] blink_ms;
    logic [15:0] blink_cnt_q;
    logic        blink_q;
    logic [15:0] flash_cnt_q;
    logic [15:0] flash_ph_q;
    logic        flash_q;
    logic        ind_level;

    always_comb begin
        if (blink_time_override_q != 8'h00) begin
            blink_ms = 16'(blink_time_override_q * OVERRIDE_UNIT_MS);
        end else if (coord_q) begin
            blink_ms = 16'(BLINK_COORD_MS);
        end else begin
            blink_ms = 16'(BLINK_NORMAL_MS);
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            blink_cnt_q <= 16'h0000;
            blink_q     <= 1'b0;
        end else if (ms_tick) begin
            if (blink_cnt_q + 16'h0001 >= blink_ms) begin
                blink_cnt_q <= 16'h0000;
                blink_q     <= !blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 16'h0001;
            end
        end
    end

    // Flash only while the indicator function is on
    always_ff @(posedge CLK) begin
        if (SRST) begin
            flash_cnt_q <= 16'h0000;
            flash_ph_q  <= 16'h0000;
            flash_q     <= 1'b0;
        end else if (RX_NODE_ID && indicator_pin_config == PIN_ALT1) begin
            flash_cnt_q <= 16'(ID_FLASH_MS);
            flash_ph_q  <= 16'h0000;
            flash_q     <= 1'b1;
        end else if (ms_tick && flash_cnt_q != 16'h0000) begin
            flash_cnt_q <= flash_cnt_q - 16'h0001;
            if (flash_ph_q == 16'(ID_BLINK_MS - 1)) begin
                flash_ph_q <= 16'h0000;
                flash_q    <= !flash_q;
            end else begin
                flash_ph_q <= flash_ph_q + 16'h0001;
            end
        end
    end

    always_comb begin
        case (sleep_mode_q)
            4'h0:             ind_level = blink_q;
            4'h1, 4'h4, 4'h5: ind_level = SLEEPING ? 1'b0 : blink_q;
            4'h7:             ind_level = (!SYNCED || NET_ASLEEP) ? 1'b1 : blink_q;
            4'h8:             ind_level = SLEEPING ? 1'b0 : (!SYNCED ? 1'b1 : blink_q);
            default:          ind_level = blink_q;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            association_indicator_pin_q <= 1'b0;
        end else begin
            association_indicator_pin_q <= flash_cnt_q != 16'h0000 ? flash_q : ind_level;
        end
    end

    // ==========================================================
    // Commissioning button and node identification
    logic btn_prev_q;
    logic id_pend_q;
    logic press;

    assign press = (btn_prev_q && !dio_s_q[BUTTON_PIN] && pincfg_lo_q[3:0] == PIN_ALT1)
                   || button_cmd;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            btn_prev_q <= 1'b0;
            id_pend_q  <= 1'b0;
            NODE_ID_TX <= 1'b0;
        end else begin
            btn_prev_q <= dio_s_q[BUTTON_PIN];
            NODE_ID_TX <= 1'b0;
            if (press && sleep_mode_q == 4'h0) begin
                NODE_ID_TX <= 1'b1;
            end else if (press && !WAKE_START) begin
                id_pend_q <= 1'b1;
            end else if (WAKE_START && (id_pend_q || press)) begin
                NODE_ID_TX <= 1'b1;
                id_pend_q  <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Received sample forwarding and wake hold
    logic [15:0] hold_cnt_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            FWD_VALID <= 1'b0;
            FWD_DATA  <= 8'h00;
        end else begin
            FWD_VALID <= RX_SAMPLE_VALID && api_mode_q;
            FWD_DATA  <= RX_SAMPLE_DATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            hold_cnt_q <= 16'h0000;
        end else if (WAKE_START && sleep_mode_q != 4'h0) begin
            hold_cnt_q <= wake_hold_time_q;
        end else if (ms_tick && hold_cnt_q != 16'h0000) begin
            hold_cnt_q <= hold_cnt_q - 16'h0001;
        end
    end
    assign STAY_AWAKE = hold_cnt_q != 16'h0000;

    // ==========================================================
    // Sample triggers
    logic [15:0] period_cnt_q;
    logic        periodic;
    logic        changed;
    logic        pend_q;
    logic        pend_query_q;
    logic        start;

    assign periodic = ms_tick && sample_period_ms_q != 16'h0000 && !SLEEPING
                      && period_cnt_q + 16'h0001 >= sample_period_ms_q;
    assign changed  = |((dio_s_q ^ dio_prev_q) & change_detect_mask_q);
    assign start    = !busy && (pend_q || pend_query_q || query_cmd);

    always_ff @(posedge CLK) begin
        if (SRST || sample_period_ms_q == 16'h0000 || SLEEPING) begin
            period_cnt_q <= 16'h0000;
        end else if (ms_tick) begin
            period_cnt_q <= periodic ? 16'h0000 : period_cnt_q + 16'h0001;
        end
    end

    // New trigger wins over the clear at start
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pend_q       <= 1'b0;
            pend_query_q <= 1'b0;
        end else begin
            if (periodic || changed) begin
                pend_q <= 1'b1;
            end else if (start) begin
                pend_q <= 1'b0;
            end
            if (query_cmd && busy) begin
                pend_query_q <= 1'b1;
            end else if (start) begin
                pend_query_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Sample set serialiser
    iosled_state_t      state_q;
    iosled_state_t      after;
    iosled_state_t      ret_q;
    logic [NUM_DIO-1:0] dmask_q;
    logic [NUM_DIO-1:0] dstate_q;
    logic [NUM_ANA-1:0] amask_q;
    logic [2:0]         ana_next;
    logic               text_q;
    logic               field_end;
    logic               advance;
    logic [7:0]         byte_d;

    function automatic logic [2:0] next_chan(input logic [NUM_ANA-1:0] m, input logic [2:0] from);
        logic [2:0] r;
        r = 3'(NUM_ANA);
        for (int c = NUM_ANA - 1; c >= 0; c--) begin
            if (m[c] && 3'(c) >= from) begin
                r = 3'(c);
            end
        end
        return r;
    endfunction : next_chan

    assign busy    = state_q != ST_IDLE;
    assign advance = busy && (!SMP_VALID || SMP_READY);
    assign ana_next = next_chan(amask_q, state_q == ST_AL ? ADC_SEL + 3'h1 : 3'h0);

    always_comb begin
        after     = ST_IDLE;
        field_end = 1'b1;
        byte_d    = 8'h00;
        case (state_q)
            ST_CNT: begin
                byte_d = SAMPLE_SETS;
                after  = ST_DMH;
            end
            ST_DMH: begin
                byte_d    = {3'h0, dmask_q[12:8]};
                after     = ST_DML;
                field_end = 1'b0;
            end
            ST_DML: begin
                byte_d = dmask_q[7:0];
                after  = ST_AM;
            end
            ST_AM: begin
                byte_d = {2'h0, amask_q};
                after  = dmask_q != '0 ? ST_DSH
                         : (ana_next != 3'(NUM_ANA) ? ST_AH : ST_IDLE);
            end
            ST_DSH: begin
                byte_d    = {3'h0, dstate_q[12:8]};
                after     = ST_DSL;
                field_end = 1'b0;
            end
            ST_DSL: begin
                byte_d = dstate_q[7:0];
                after  = ana_next != 3'(NUM_ANA) ? ST_AH : ST_IDLE;
            end
            ST_AH: begin
                byte_d    = ADC_DATA[15:8];
                after     = ST_AL;
                field_end = 1'b0;
            end
            ST_AL: begin
                byte_d = ADC_DATA[7:0];
                after  = ana_next != 3'(NUM_ANA) ? ST_AH : ST_IDLE;
            end
            ST_CR: begin
                byte_d    = CR_BYTE;
                after     = ret_q;
                field_end = 1'b0;
            end
            default: begin
                field_end = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_q       <= ST_IDLE;
            ret_q         <= ST_IDLE;
            dmask_q       <= '0;
            dstate_q      <= '0;
            amask_q       <= '0;
            text_q        <= 1'b0;
            ADC_SEL       <= 3'h0;
            SMP_VALID     <= 1'b0;
            SMP_DATA      <= 8'h00;
            SMP_LAST      <= 1'b0;
            SMP_TO_SERIAL <= 1'b0;
            SMP_API_FRAME <= 1'b0;
            SMP_DEST      <= 64'h0;
        end else if (start) begin
            state_q       <= ST_CNT;
            dmask_q       <= dmask;
            dstate_q      <= dio_s_q & dmask;
            amask_q       <= amask;
            SMP_TO_SERIAL <= query_cmd || pend_query_q;
            SMP_API_FRAME <= api_mode_q;
            text_q        <= (query_cmd || pend_query_q) && !api_mode_q;
            SMP_DEST      <= {destination_addr_high_q, destination_addr_low_q};
            if (SMP_READY) begin
                SMP_VALID <= 1'b0;
                SMP_LAST  <= 1'b0;
            end
        end else if (advance) begin
            SMP_VALID <= 1'b1;
            SMP_DATA  <= byte_d;
            if (after == ST_AH && state_q != ST_CR) begin
                ADC_SEL <= ana_next;
            end
            if (text_q && field_end) begin
                state_q  <= ST_CR;
                ret_q    <= after;
                SMP_LAST <= 1'b0;
            end else begin
                state_q  <= after;
                SMP_LAST <= after == ST_IDLE;
            end
        end else if (SMP_READY) begin
            SMP_VALID <= 1'b0;
            SMP_LAST  <= 1'b0;
        end
    end
endmodule : iosled_top
`default_nettype wire
